// ===== hdl/dflc_defs.svh
`ifndef DFLC_DEFS_SVH
`define DFLC_DEFS_SVH

// Register offsets
`define DFLC_ADDR_W          8
`define DFLC_OFS_FB0_HIGH    8'h17
`define DFLC_OFS_FB0_MID     8'h18
`define DFLC_OFS_FB0_LOW     8'h19
`define DFLC_OFS_FB1_HIGH    8'h1A
`define DFLC_OFS_FB1_MID     8'h1B
`define DFLC_OFS_FB1_LOW     8'h1C
`define DFLC_OFS_LOOP_BW     8'h23
`define DFLC_OFS_DAMP_GAIN   8'h24
`define DFLC_OFS_TIGHT_CFG   8'h25
`define DFLC_OFS_TIGHT_THR   8'h28
`define DFLC_OFS_SLEW_HOLD   8'h2F
`define DFLC_OFS_LOCK_WIN    8'h30
`define DFLC_OFS_MOD_INT_HI  8'h31
`define DFLC_OFS_MOD_INT_LO  8'h32
`define DFLC_OFS_MOD_FRAC_HI 8'h33
`define DFLC_OFS_MOD_FRAC_MD 8'h34
`define DFLC_OFS_MOD_FRAC_LO 8'h35
`define DFLC_OFS_MOD_ORDER   8'h3A
// Read-only status of the selected loop settings
`define DFLC_OFS_ACTIVE_BW   8'h40
`define DFLC_OFS_ACTIVE_DAMP 8'h41

// Field positions (low bit)
`define DFLC_POS_LCK_BW      4
`define DFLC_POS_ACQ_BW      0
`define DFLC_POS_LCK_DAMP    5
`define DFLC_POS_ACQ_DAMP    2
`define DFLC_POS_GAIN        0
`define DFLC_POS_TG_DAMP     5
`define DFLC_POS_TG_HYS      4
`define DFLC_POS_TG_BW       1
`define DFLC_POS_TG_THR      1
`define DFLC_POS_SLEW        6
`define DFLC_POS_HOLD        3
`define DFLC_POS_HOLDAVG     1
`define DFLC_POS_QUICK       0
`define DFLC_POS_ORDER       6
`define DFLC_POS_DCO_GAIN    4
`define DFLC_POS_DITHER      0

// Reset values
`define DFLC_RST_FB_DIV      24'h070000
`define DFLC_RST_BW          4'h7
`define DFLC_RST_DAMP        3'h3
`define DFLC_RST_GAIN        2'h1
`define DFLC_RST_TG_BW       3'h3
`define DFLC_RST_TG_DAMP     3'h0
`define DFLC_RST_TG_THR      7'h00
`define DFLC_RST_LOCK_WIN    8'h3F
`define DFLC_RST_MOD_INT     9'h02E
`define DFLC_RST_MOD_FRAC    21'h1C0000
`define DFLC_RST_ORDER       2'h3
`define DFLC_RST_DCO_GAIN    2'h1

// Code limits
`define DFLC_BW_MAX          4'hA
`define DFLC_DAMP_MIN        3'h1
`define DFLC_DAMP_MAX        3'h5

`endif

// ===== hdl/dflc_pkg.sv
package dflc_pkg;

  typedef enum logic [1:0] {
    DFLC_MODE_LOCKED,
    DFLC_MODE_ACQUIRE,
    DFLC_MODE_TIGHT
  } dflc_mode_t;

  typedef struct packed {
    logic [23:0] fb_div_ratio_ref0;
    logic [23:0] fb_div_ratio_ref1;
    logic [3:0]  locked_bandwidth_code;
    logic [3:0]  acquire_bandwidth_code;
    logic [2:0]  locked_damping_code;
    logic [2:0]  acquire_damping_code;
    logic [1:0]  loop_filter_gain_code;
    logic [2:0]  tight_hold_damping_code;
    logic        tight_hold_hysteresis;
    logic [2:0]  tight_hold_bandwidth_code;
    logic [6:0]  tight_hold_threshold;
    logic [1:0]  slew_code;
    logic [1:0]  holdover_mode;
    logic        holdover_average;
    logic        quick_acquire_enable;
    logic [7:0]  lock_window;
    logic [8:0]  modulator_int;
    logic [20:0] modulator_frac;
    logic [1:0]  modulator_order;
    logic [1:0]  dco_gain_code;
    logic [2:0]  dither_gain_code;
    logic [7:0]  rd_data;
  } dflc_state_t;

endpackage

// ===== hdl/dflc_regs.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "dflc_defs.svh"

module dflc_regs (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_ref_sel,
  input  wire logic       i_phase_locked,
  input  wire logic       i_tight_lock,
  output logic      [7:0] o_rdata,
  output logic     [23:0] o_fb_div_ratio,
  output logic      [3:0] o_active_bandwidth_code,
  output logic      [2:0] o_active_damping_code,
  output logic            o_active_bw_valid,
  output logic            o_active_damp_valid,
  output logic      [1:0] o_loop_filter_gain_code,
  output logic      [6:0] o_tight_hold_threshold,
  output logic            o_tight_hold_hysteresis,
  output logic      [1:0] o_slew_code,
  output logic      [1:0] o_holdover_mode,
  output logic            o_holdover_average,
  output logic      [7:0] o_lock_window,
  output logic      [8:0] o_modulator_int,
  output logic     [20:0] o_modulator_frac,
  output logic      [1:0] o_modulator_order,
  output logic      [1:0] o_dco_gain_code,
  output logic      [2:0] o_dither_gain_code
);

  dflc_pkg::dflc_state_t st;
  dflc_pkg::dflc_state_t next_st;
  dflc_pkg::dflc_mode_t  mode;
  logic [3:0]            act_bw;
  logic [2:0]            act_damp;
  logic [7:0]            rd_mux;

  // Loop mode selection
  always_comb begin
    if (!st.quick_acquire_enable || i_phase_locked) begin
      mode = (i_phase_locked && i_tight_lock) ? dflc_pkg::DFLC_MODE_TIGHT : dflc_pkg::DFLC_MODE_LOCKED;
    end else begin
      mode = dflc_pkg::DFLC_MODE_ACQUIRE;
    end
  end

  always_comb begin
    unique case (mode)
      dflc_pkg::DFLC_MODE_ACQUIRE: begin
        act_bw   = st.acquire_bandwidth_code;
        act_damp = st.acquire_damping_code;
      end
      dflc_pkg::DFLC_MODE_TIGHT: begin
        // Tight ladder 1 Hz at 001 equals locked ladder code 0001, so code maps directly
        act_bw   = (st.tight_hold_bandwidth_code == 3'h0) ? st.locked_bandwidth_code
                                                          : {1'b0, st.tight_hold_bandwidth_code};
        act_damp = (st.tight_hold_damping_code == 3'h0) ? st.locked_damping_code
                                                        : st.tight_hold_damping_code;
      end
      dflc_pkg::DFLC_MODE_LOCKED: begin
        act_bw   = st.locked_bandwidth_code;
        act_damp = st.locked_damping_code;
      end
      default: begin
        act_bw   = st.locked_bandwidth_code;
        act_damp = st.locked_damping_code;
      end
    endcase
  end

  // Reserved codes are stored as written but flagged, so the loop can hold its last good setting
  assign o_active_bw_valid   = (act_bw <= `DFLC_BW_MAX);
  assign o_active_damp_valid = (act_damp >= `DFLC_DAMP_MIN) && (act_damp <= `DFLC_DAMP_MAX);

  // Read mux; reserved bits read as zero
  always_comb begin
    unique case (i_addr)
      `DFLC_OFS_FB0_HIGH:    rd_mux = st.fb_div_ratio_ref0[23:16];
      `DFLC_OFS_FB0_MID:     rd_mux = st.fb_div_ratio_ref0[15:8];
      `DFLC_OFS_FB0_LOW:     rd_mux = st.fb_div_ratio_ref0[7:0];
      `DFLC_OFS_FB1_HIGH:    rd_mux = st.fb_div_ratio_ref1[23:16];
      `DFLC_OFS_FB1_MID:     rd_mux = st.fb_div_ratio_ref1[15:8];
      `DFLC_OFS_FB1_LOW:     rd_mux = st.fb_div_ratio_ref1[7:0];
      `DFLC_OFS_LOOP_BW:     rd_mux = {st.locked_bandwidth_code, st.acquire_bandwidth_code};
      `DFLC_OFS_DAMP_GAIN:   rd_mux = {st.locked_damping_code, st.acquire_damping_code, st.loop_filter_gain_code};
      `DFLC_OFS_TIGHT_CFG:   rd_mux = {st.tight_hold_damping_code, st.tight_hold_hysteresis,
                                       st.tight_hold_bandwidth_code, 1'b0};
      `DFLC_OFS_TIGHT_THR:   rd_mux = {st.tight_hold_threshold, 1'b0};
      `DFLC_OFS_SLEW_HOLD:   rd_mux = {st.slew_code, 1'b0, st.holdover_mode, 1'b0,
                                       st.holdover_average, st.quick_acquire_enable};
      `DFLC_OFS_LOCK_WIN:    rd_mux = st.lock_window;
      `DFLC_OFS_MOD_INT_HI:  rd_mux = {7'h00, st.modulator_int[8]};
      `DFLC_OFS_MOD_INT_LO:  rd_mux = st.modulator_int[7:0];
      `DFLC_OFS_MOD_FRAC_HI: rd_mux = {3'h0, st.modulator_frac[20:16]};
      `DFLC_OFS_MOD_FRAC_MD: rd_mux = st.modulator_frac[15:8];
      `DFLC_OFS_MOD_FRAC_LO: rd_mux = st.modulator_frac[7:0];
      `DFLC_OFS_MOD_ORDER:   rd_mux = {st.modulator_order, st.dco_gain_code, 1'b0, st.dither_gain_code};
      `DFLC_OFS_ACTIVE_BW:   rd_mux = {mode, 2'h0, act_bw};
      `DFLC_OFS_ACTIVE_DAMP: rd_mux = {5'h00, act_damp};
      default:               rd_mux = 8'h00;
    endcase
  end

  // Register update
  always_comb begin
    next_st         = st;
    next_st.rd_data = i_rd ? rd_mux : 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        `DFLC_OFS_FB0_HIGH:    next_st.fb_div_ratio_ref0[23:16] = i_wdata;
        `DFLC_OFS_FB0_MID:     next_st.fb_div_ratio_ref0[15:8]  = i_wdata;
        `DFLC_OFS_FB0_LOW:     next_st.fb_div_ratio_ref0[7:0]   = i_wdata;
        `DFLC_OFS_FB1_HIGH:    next_st.fb_div_ratio_ref1[23:16] = i_wdata;
        `DFLC_OFS_FB1_MID:     next_st.fb_div_ratio_ref1[15:8]  = i_wdata;
        `DFLC_OFS_FB1_LOW:     next_st.fb_div_ratio_ref1[7:0]   = i_wdata;
        `DFLC_OFS_LOOP_BW: begin
          next_st.locked_bandwidth_code  = i_wdata[`DFLC_POS_LCK_BW +: 4];
          next_st.acquire_bandwidth_code = i_wdata[`DFLC_POS_ACQ_BW +: 4];
        end
        `DFLC_OFS_DAMP_GAIN: begin
          next_st.locked_damping_code   = i_wdata[`DFLC_POS_LCK_DAMP +: 3];
          next_st.acquire_damping_code  = i_wdata[`DFLC_POS_ACQ_DAMP +: 3];
          next_st.loop_filter_gain_code = i_wdata[`DFLC_POS_GAIN +: 2];
        end
        `DFLC_OFS_TIGHT_CFG: begin
          next_st.tight_hold_damping_code   = i_wdata[`DFLC_POS_TG_DAMP +: 3];
          next_st.tight_hold_hysteresis     = i_wdata[`DFLC_POS_TG_HYS];
          next_st.tight_hold_bandwidth_code = i_wdata[`DFLC_POS_TG_BW +: 3];
        end
        `DFLC_OFS_TIGHT_THR:   next_st.tight_hold_threshold = i_wdata[`DFLC_POS_TG_THR +: 7];
        `DFLC_OFS_SLEW_HOLD: begin
          next_st.slew_code            = i_wdata[`DFLC_POS_SLEW +: 2];
          next_st.holdover_mode        = i_wdata[`DFLC_POS_HOLD +: 2];
          next_st.holdover_average     = i_wdata[`DFLC_POS_HOLDAVG];
          next_st.quick_acquire_enable = i_wdata[`DFLC_POS_QUICK];
        end
        `DFLC_OFS_LOCK_WIN:    next_st.lock_window          = i_wdata;
        `DFLC_OFS_MOD_INT_HI:  next_st.modulator_int[8]     = i_wdata[0];
        `DFLC_OFS_MOD_INT_LO:  next_st.modulator_int[7:0]   = i_wdata;
        `DFLC_OFS_MOD_FRAC_HI: next_st.modulator_frac[20:16] = i_wdata[4:0];
        `DFLC_OFS_MOD_FRAC_MD: next_st.modulator_frac[15:8] = i_wdata;
        `DFLC_OFS_MOD_FRAC_LO: next_st.modulator_frac[7:0]  = i_wdata;
        `DFLC_OFS_MOD_ORDER: begin
          next_st.modulator_order  = i_wdata[`DFLC_POS_ORDER +: 2];
          next_st.dco_gain_code    = i_wdata[`DFLC_POS_DCO_GAIN +: 2];
          next_st.dither_gain_code = i_wdata[`DFLC_POS_DITHER +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st                           <= '0;
      st.fb_div_ratio_ref0         <= `DFLC_RST_FB_DIV;
      st.fb_div_ratio_ref1         <= `DFLC_RST_FB_DIV;
      st.locked_bandwidth_code     <= `DFLC_RST_BW;
      st.acquire_bandwidth_code    <= `DFLC_RST_BW;
      st.locked_damping_code       <= `DFLC_RST_DAMP;
      st.acquire_damping_code      <= `DFLC_RST_DAMP;
      st.loop_filter_gain_code     <= `DFLC_RST_GAIN;
      st.tight_hold_bandwidth_code <= `DFLC_RST_TG_BW;
      st.tight_hold_damping_code   <= `DFLC_RST_TG_DAMP;
      st.tight_hold_threshold      <= `DFLC_RST_TG_THR;
      st.lock_window               <= `DFLC_RST_LOCK_WIN;
      st.modulator_int             <= `DFLC_RST_MOD_INT;
      st.modulator_frac            <= `DFLC_RST_MOD_FRAC;
      st.modulator_order           <= `DFLC_RST_ORDER;
      st.dco_gain_code             <= `DFLC_RST_DCO_GAIN;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata                 = st.rd_data;
  assign o_fb_div_ratio          = i_ref_sel ? st.fb_div_ratio_ref1 : st.fb_div_ratio_ref0;
  assign o_active_bandwidth_code = act_bw;
  assign o_active_damping_code   = act_damp;
  assign o_loop_filter_gain_code = st.loop_filter_gain_code;
  assign o_tight_hold_threshold  = st.tight_hold_threshold;
  assign o_tight_hold_hysteresis = st.tight_hold_hysteresis;
  assign o_slew_code             = st.slew_code;
  assign o_holdover_mode         = st.holdover_mode;
  assign o_holdover_average      = st.holdover_average;
  assign o_lock_window           = st.lock_window;
  assign o_modulator_int         = st.modulator_int;
  assign o_modulator_frac        = st.modulator_frac;
  assign o_modulator_order       = st.modulator_order;
  assign o_dco_gain_code         = st.dco_gain_code;
  assign o_dither_gain_code      = st.dither_gain_code;

endmodule // dflc_regs

// ===== dv/dflc_regs_sva.sv
`timescale 1ns/1ps
module dflc_regs_sva (
  input wire logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_ref_sel, i_phase_locked, i_tight_lock,
  input wire logic [7:0]  i_addr, i_wdata, o_rdata,
  input wire logic [23:0] o_fb_div_ratio,
  input wire logic [3:0]  o_active_bandwidth_code,
  input wire logic [2:0]  o_active_damping_code,
  input wire logic        o_active_bw_valid, o_active_damp_valid,
  input wire logic [1:0]  o_loop_filter_gain_code
);
  logic [7:0] fb_lo;
  logic [3:0] wd_hi;
  logic [1:0] wd_gain;
  assign fb_lo   = o_fb_div_ratio[7:0];
  assign wd_hi   = i_wdata[7:4];
  assign wd_gain = i_wdata[1:0];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_fb0_low_write: assert property ((i_wr && i_addr == 8'h19 && !i_ref_sel) ##1 !i_ref_sel
    |-> fb_lo == $past(i_wdata))
    else $error("ref0 divider low byte not taken");
  a_fb1_low_write: assert property ((i_wr && i_addr == 8'h1C && i_ref_sel) ##1 i_ref_sel
    |-> fb_lo == $past(i_wdata))
    else $error("ref1 divider low byte not taken");
  a_fb0_read_back: assert property (i_rd && i_addr == 8'h19 && !i_ref_sel |=> o_rdata == $past(fb_lo))
    else $error("ref0 divider read mismatch");
  a_gain_write: assert property (i_wr && i_addr == 8'h24 |=> o_loop_filter_gain_code == $past(wd_gain))
    else $error("gain code not written");
  a_gain_hold: assert property (!(i_wr && i_addr == 8'h24) |=> $stable(o_loop_filter_gain_code))
    else $error("gain code changed without write");
  a_locked_bw_used: assert property ((i_wr && i_addr == 8'h23 && i_phase_locked && !i_tight_lock)
    ##1 (i_phase_locked && !i_tight_lock) |-> o_active_bandwidth_code == $past(wd_hi))
    else $error("locked bandwidth not applied");
  a_bw_code_flag: assert property (o_active_bw_valid == (o_active_bandwidth_code <= 4'hA))
    else $error("bandwidth valid flag wrong");
  a_damp_code_flag: assert property (o_active_damp_valid ==
    (o_active_damping_code >= 3'h1 && o_active_damping_code <= 3'h5))
    else $error("damping valid flag wrong");
  c_loop_bw_write: cover property (i_wr && i_addr == 8'h23);
  c_any_read: cover property (i_rd ##1 o_rdata != 8'h00);
  c_tight_lock: cover property (i_phase_locked && i_tight_lock);
endmodule // dflc_regs_sva

bind dflc_regs dflc_regs_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd),
  .i_ref_sel(i_ref_sel), .i_phase_locked(i_phase_locked), .i_tight_lock(i_tight_lock), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_fb_div_ratio(o_fb_div_ratio),
  .o_active_bandwidth_code(o_active_bandwidth_code), .o_active_damping_code(o_active_damping_code),
  .o_active_bw_valid(o_active_bw_valid), .o_active_damp_valid(o_active_damp_valid),
  .o_loop_filter_gain_code(o_loop_filter_gain_code));

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_ref_sel, i_phase_locked, i_tight_lock;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic [23:0] o_fb_div_ratio;
  logic [3:0]  o_active_bandwidth_code;
  logic [2:0]  o_active_damping_code;
  logic        o_active_bw_valid, o_active_damp_valid;
  logic [1:0]  o_loop_filter_gain_code;
  logic [7:0]  o_lock_window;
  logic [8:0]  o_modulator_int;
  logic [20:0] o_modulator_frac;
  int          failures, total_checks;
  logic [7:0]  addrs [18] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h23, 8'h24, 8'h25,
                              8'h28, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3A};
  logic [7:0]  rstv [18]  = '{8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h77, 8'h6D, 8'h06,
                              8'h00, 8'h00, 8'h3F, 8'h00, 8'h2E, 8'h1C, 8'h00, 8'h00, 8'hD0};
  // Reserved bits must read back 0 even after writing ones
  logic [7:0]  mask [18]  = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE,
                              8'hFE, 8'hDB, 8'hFF, 8'h01, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hF7};

  dflc_regs uut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_ref_sel(i_ref_sel), .i_phase_locked(i_phase_locked), .i_tight_lock(i_tight_lock), .o_rdata(o_rdata),
    .o_fb_div_ratio(o_fb_div_ratio), .o_active_bandwidth_code(o_active_bandwidth_code),
    .o_active_damping_code(o_active_damping_code), .o_active_bw_valid(o_active_bw_valid),
    .o_active_damp_valid(o_active_damp_valid), .o_loop_filter_gain_code(o_loop_filter_gain_code),
    .o_tight_hold_threshold(), .o_tight_hold_hysteresis(), .o_slew_code(), .o_holdover_mode(),
    .o_holdover_average(), .o_lock_window(o_lock_window), .o_modulator_int(o_modulator_int),
    .o_modulator_frac(o_modulator_frac),
    .o_modulator_order(), .o_dco_gain_code(), .o_dither_gain_code());

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask

  task automatic st(input logic lk, input logic tg, input logic [3:0] bw, input logic [2:0] dp);
    @(posedge i_clk_sys);
    i_phase_locked <= lk;
    i_tight_lock   <= tg;
    #1;
    check(o_active_bandwidth_code, bw);
    check(o_active_damping_code, dp);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_ref_sel = 1'b0;
    i_phase_locked = 1'b0;
    i_tight_lock = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    i_ref_sel <= 1'b1;
    #1 check(o_fb_div_ratio, 24'h070000);
    @(posedge i_clk_sys);
    i_ref_sel <= 1'b0;
    #1 check(o_fb_div_ratio, 24'h070000);
    check(o_lock_window, 24'h00003F);
    check(o_modulator_int, 24'h00002E);
    check(o_modulator_frac, 24'h1C0000);
    for (int i = 0; i < 18; i++) rd_chk(addrs[i], rstv[i]);
    for (int i = 0; i < 18; i++) wr(addrs[i], 8'hFF);
    check(o_lock_window, 24'h0000FF);
    check(o_modulator_int, 24'h0001FF);
    check(o_modulator_frac, 24'h1FFFFF);
    for (int i = 0; i < 18; i++) rd_chk(addrs[i], mask[i]);
    wr(8'h1D, 8'hFF);
    rd_chk(8'h1D, 8'h00);
    @(posedge i_clk_sys);
    i_ref_sel <= 1'b1;
    wr(8'h1A, 8'hAB);
    wr(8'h1B, 8'hCD);
    wr(8'h1C, 8'hEF);
    check(o_fb_div_ratio, 24'hABCDEF);
    @(posedge i_clk_sys);
    i_ref_sel <= 1'b0;
    #1 check(o_fb_div_ratio, 24'hFFFFFF);
    for (int g = 0; g < 4; g++) begin
      wr(8'h24, {6'b010100, 2'(g)});
      check(o_loop_filter_gain_code, 24'(g));
    end
    wr(8'h23, 8'h58);
    wr(8'h25, 8'h00);
    wr(8'h2F, 8'h01);
    st(1'b0, 1'b0, 4'h8, 3'h4);
    st(1'b1, 1'b0, 4'h5, 3'h2);
    st(1'b1, 1'b1, 4'h5, 3'h2);
    wr(8'h25, 8'hAC);
    st(1'b1, 1'b1, 4'h6, 3'h5);
    rd_chk(8'h40, 8'h86);
    rd_chk(8'h41, 8'h05);
    wr(8'h2F, 8'h00);
    st(1'b0, 1'b0, 4'h5, 3'h2);
    st(1'b1, 1'b0, 4'h5, 3'h2);
    wr(8'h23, 8'hB0);
    wr(8'h24, 8'h03);
    st(1'b1, 1'b0, 4'hB, 3'h0);
    check(o_active_bw_valid, 1'b0);
    check(o_active_damp_valid, 1'b0);
    results();
  end
endmodule // tb_top
